// >>> verilog/mmu_defines.vh
`ifndef MMU_DEFINES_VH
`define MMU_DEFINES_VH
// register offsets on the plain register port
`define A_MSW      8'h00
`define A_CTRL     8'h04
`define A_HBASE    8'h08
`define A_HMASK    8'h0c
`define A_INVAL    8'h10
`define A_CAUSE    8'h14
`define A_FADDR    8'h18
`define A_STAT     8'h1c
`define A_SEG_HI   2'h1
`define A_BAT_HI   3'h4
// machine state word bits and reset value, control register bit
`define MSW_IXE    0
`define MSW_DXE    1
`define MSW_USER   2
`define MSW_RST    32'h0000_0000
`define CTRL_BCAST 0
// segment register fields
`define SEG_T      31
`define SEG_KS     30
`define SEG_KU     29
// data fault cause bits
`define CS_NOTFND  1
`define CS_PROT    4
`define CS_STORE   6
// access classes
`define CL_IFETCH  2'h0
`define CL_DATA    2'h1
`define CL_IOCTL   2'h2
// page protection codes
`define PP_RW      2'h2
`define PP_RO      2'h3
`define PP_KRO     2'h1
// table walk, buffer sets and fetch cache
`define ENT_LAST   3'h7
`define SETS       128
`define ITC_N      4
`define AGE_OLD    2'h3
`endif

// >>> verilog/address_translation_mmu.v
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Function
// - translate only when matching enable bit set
// - 4G space, 256M segments, 4K pages
// - block sizes 128K to 8M by mask
// - 52-bit virtual address from segment id
// - buffer lookup adds no extra cycles
// - 256 entries, two-way set associative
// - hardware hashed table search on miss
// - selective invalidation of buffer sets
// - optional broadcast of invalidations
// - four block entries written by software
// - four-entry instruction translation cache
// - cache kept consistent, LRU replacement
// - table power of 2, base aligned
// - groups of eight 8-byte entries
// - failures reported as fault exceptions
// - permission checked on blocks and pages
// - fetch, data and io-controller classes
// - no tracking of table updates
// - cause bit 1 on translation not found
// - cause bit 4 on protection violation
`include "mmu_defines.vh"

module address_translation_mmu (
    // clock and reset
    input  wire        mclk,
    input  wire        sys_rst,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // translation request
    input  wire        req_valid,
    input  wire [1:0]  req_class,
    input  wire        req_store,
    input  wire [31:0] req_addr,
    output reg         req_ready,
    // translation answer
    output reg         rsp_valid,
    output reg  [31:0] rsp_paddr,
    output reg         rsp_io,
    output reg         rsp_fault,
    output reg         instr_fault,
    output reg         data_fault,
    // page table memory
    output reg         mem_rd,
    output reg  [31:0] mem_addr,
    input  wire [63:0] mem_rdata,
    input  wire        mem_ack,
    // remote invalidation
    output reg         bcast_inval,
    output reg  [31:0] bcast_ea,
    input  wire        snoop_inval,
    input  wire [31:0] snoop_ea
);

localparam S_IDLE  = 2'h0;
localparam S_WREQ  = 2'h1;
localparam S_WAIT  = 2'h2;
localparam S_RETRY = 2'h3;

reg  [1:0]  st_q, cls_q;
reg  [31:0] msw_q, ctrl_q, hbase_q, hmask_q;
reg  [31:0] cause_q, faddr_q, ea_q, grp_q;
reg  [31:0] seg_q [0:15];
reg  [31:0] bat_u [0:3];
reg  [31:0] bat_l [0:3];
// entry: tag 33, rpn 20, pp 2
reg  [54:0] ubuf0 [0:`SETS-1];
reg  [54:0] ubuf1 [0:`SETS-1];
reg  [`SETS-1:0] uv0_q, uv1_q, lru_q;
reg  [19:0] it_tag [0:3];
reg  [19:0] it_pa  [0:3];
reg  [1:0]  it_pp  [0:3];
reg  [1:0]  age_q  [0:3];
reg  [3:0]  itv_q;
reg         str_q, sec_q;
reg  [18:0] hash_q;
reg  [2:0]  pidx_q;

reg  [31:0] cur_ea, seg, bpa, pa, rdv;
reg  [1:0]  cur_cls, bpp, iidx, ivic, itch, pp;
reg  [6:0]  uidx, iv_idx;
reg  [32:0] utag;
reg  [54:0] e0, e1;
reg         cur_st, key, ifc, xen, uh0, uh1, bhit, ihit, hit;
reg         io, fill, prot, iofault, go, entry_hit, wway, inval;
integer     i;
integer     k;

// access allowed for the given key and page protection code
function prot_ok;
    input [1:0] ppc;
    input       k;
    input       wr;
    begin
        if (ppc == `PP_RW)
            prot_ok = 1'b1;
        else if (ppc == `PP_RO)
            prot_ok = !wr;
        else if (ppc == `PP_KRO)
            prot_ok = !k || !wr;
        else
            prot_ok = !k;
    end
endfunction

// aligned base lets the masked hash be or-ed in, no adder
function [31:0] grp_addr;
    input [18:0] h;
    begin
        grp_addr = hbase_q | {7'h0, h & hmask_q[18:0], 6'h0};
    end
endfunction

// translation of the current access, combinational
always @* begin
    if (st_q == S_IDLE) begin
        cur_ea  = req_addr;
        cur_cls = req_class;
        cur_st  = req_store;
    end else begin
        cur_ea  = ea_q;
        cur_cls = cls_q;
        cur_st  = str_q;
    end
    seg  = seg_q[cur_ea[31:28]];
    key  = msw_q[`MSW_USER] ? seg[`SEG_KU] : seg[`SEG_KS];
    ifc  = cur_cls == `CL_IFETCH;
    xen  = ifc ? msw_q[`MSW_IXE] : msw_q[`MSW_DXE];
    uidx = cur_ea[18:12];
    utag = {seg[23:0], cur_ea[27:19]};
    e0   = ubuf0[uidx];
    e1   = ubuf1[uidx];
    uh0  = uv0_q[uidx] && e0[54:22] == utag;
    uh1  = uv1_q[uidx] && e1[54:22] == utag;
    bhit = 1'b0;
    bpa  = 32'h0;
    bpp  = 2'h0;
    for (i = 3; i >= 0; i = i - 1) begin
        if (bat_u[i][0] && ((cur_ea[31:17] ^ bat_u[i][31:17])
                & ~{9'h0, bat_u[i][7:2]}) == 15'h0) begin
            bhit = 1'b1;
            bpa  = {bat_l[i][31:17] | (cur_ea[31:17]
                    & {9'h0, bat_u[i][7:2]}), cur_ea[16:0]};
            bpp  = bat_l[i][1:0];
        end
    end
    ihit = 1'b0;
    iidx = 2'h0;
    ivic = 2'h0;
    for (i = 3; i >= 0; i = i - 1) begin
        if (itv_q[i] && it_tag[i] == cur_ea[31:12]) begin
            ihit = 1'b1;
            iidx = i[1:0];
        end
        if (age_q[i] == `AGE_OLD)
            ivic = i[1:0];
    end
    for (i = 3; i >= 0; i = i - 1)
        if (!itv_q[i])
            ivic = i[1:0];
    itch = ihit ? iidx : ivic;
    hit  = 1'b1;
    pa   = cur_ea;
    pp   = `PP_RW;
    io   = 1'b0;
    fill = 1'b0;
    if (!xen)
        hit = 1'b1;
    else if (seg[`SEG_T])
        io = 1'b1;
    else if (ifc && ihit) begin
        pa = {it_pa[iidx], cur_ea[11:0]};
        pp = it_pp[iidx];
    end else if (bhit) begin
        pa   = bpa;
        pp   = bpp;
        fill = ifc;
    end else if (uh0 || uh1) begin
        pa   = {uh0 ? e0[21:2] : e1[21:2], cur_ea[11:0]};
        pp   = uh0 ? e0[1:0] : e1[1:0];
        fill = ifc;
    end else begin
        hit = 1'b0;
    end
    prot    = xen && !io && hit && !prot_ok(pp, key, cur_st && !ifc);
    iofault = xen && io && ifc;
    go      = (st_q == S_IDLE && req_valid) || st_q == S_RETRY;
    entry_hit = mem_rdata[63] && mem_rdata[62:39] == hash_vsid(ea_q)
              && mem_rdata[38] == sec_q
              && mem_rdata[37:32] == ea_q[27:22];
    wway    = !uv0_q[ea_q[18:12]] ? 1'b0
            : !uv1_q[ea_q[18:12]] ? 1'b1 : lru_q[ea_q[18:12]];
    inval   = (reg_wr && reg_addr == `A_INVAL) || snoop_inval;
    iv_idx  = (reg_wr && reg_addr == `A_INVAL) ? reg_wdata[18:12]
                                               : snoop_ea[18:12];
end

function [23:0] hash_vsid;
    input [31:0] ea;
    begin
        hash_vsid = seg_q[ea[31:28]][23:0];
    end
endfunction

// register read mux
always @* begin
    rdv = 32'h0;
    if (reg_addr == `A_MSW)
        rdv = msw_q;
    else if (reg_addr == `A_CTRL)
        rdv = ctrl_q;
    else if (reg_addr == `A_HBASE)
        rdv = hbase_q;
    else if (reg_addr == `A_HMASK)
        rdv = hmask_q;
    else if (reg_addr == `A_CAUSE)
        rdv = cause_q;
    else if (reg_addr == `A_FADDR)
        rdv = faddr_q;
    else if (reg_addr == `A_STAT)
        rdv = {28'h0, sec_q, st_q != S_IDLE, st_q};
    else if (reg_addr[7:6] == `A_SEG_HI)
        rdv = seg_q[reg_addr[5:2]];
    else if (reg_addr[7:5] == `A_BAT_HI)
        rdv = reg_addr[2] ? bat_l[reg_addr[4:3]] : bat_u[reg_addr[4:3]];
end

always @(posedge mclk) begin
    if (sys_rst) begin
        st_q        <= S_IDLE;
        msw_q       <= `MSW_RST;
        ctrl_q      <= 32'h0;
        hbase_q     <= 32'h0;
        hmask_q     <= 32'h0;
        cause_q     <= 32'h0;
        faddr_q     <= 32'h0;
        uv0_q       <= {`SETS{1'b0}};
        uv1_q       <= {`SETS{1'b0}};
        lru_q       <= {`SETS{1'b0}};
        itv_q       <= 4'h0;
        for (k = 0; k < `ITC_N; k = k + 1) begin
            age_q[k] <= k[1:0];
            bat_u[k] <= 32'h0;
        end
        sec_q       <= 1'b0;
        reg_rdata   <= 32'h0;
        req_ready   <= 1'b1;
        rsp_valid   <= 1'b0;
        rsp_paddr   <= 32'h0;
        rsp_io      <= 1'b0;
        rsp_fault   <= 1'b0;
        instr_fault <= 1'b0;
        data_fault  <= 1'b0;
        mem_rd      <= 1'b0;
        mem_addr    <= 32'h0;
        bcast_inval <= 1'b0;
        bcast_ea    <= 32'h0;
    end else begin
        rsp_valid   <= 1'b0;
        instr_fault <= 1'b0;
        data_fault  <= 1'b0;
        mem_rd      <= 1'b0;
        bcast_inval <= 1'b0;
        reg_rdata   <= reg_rd ? rdv : 32'h0;
        if (go) begin
            ea_q  <= cur_ea;
            cls_q <= cur_cls;
            str_q <= cur_st;
            if (hit || iofault) begin
                rsp_valid   <= 1'b1;
                rsp_paddr   <= (prot || iofault) ? cur_ea : pa;
                rsp_io      <= io;
                rsp_fault   <= prot || iofault;
                instr_fault <= ifc && (prot || iofault);
                data_fault  <= !ifc && prot;
                req_ready   <= 1'b1;
                st_q        <= S_IDLE;
                if (!ifc && prot) begin
                    cause_q <= 32'h0 | (32'h1 << `CS_PROT)
                             | ({31'h0, cur_st} << `CS_STORE);
                    faddr_q <= cur_ea;
                end
                if (xen && !io && !ifc && (uh0 || uh1) && !bhit)
                    lru_q[uidx] <= uh0;
                if (ifc && (ihit || fill) && !prot) begin
                    for (k = 0; k < `ITC_N; k = k + 1)
                        if (k[1:0] == itch)
                            age_q[k] <= 2'h0;
                        else if (age_q[k] < age_q[itch])
                            age_q[k] <= age_q[k] + 2'h1;
                    if (fill) begin
                        itv_q[itch]  <= 1'b1;
                        it_tag[itch] <= cur_ea[31:12];
                        it_pa[itch]  <= pa[31:12];
                        it_pp[itch]  <= pp;
                    end
                end
            end else begin
                // miss everywhere: start the primary group search
                req_ready <= 1'b0;
                hash_q    <= seg[18:0] ^ {3'h0, cur_ea[27:12]};
                grp_q     <= grp_addr(seg[18:0] ^ {3'h0, cur_ea[27:12]});
                pidx_q    <= 3'h0;
                sec_q     <= 1'b0;
                st_q      <= S_WREQ;
            end
        end else if (st_q == S_WREQ) begin
            mem_rd   <= 1'b1;
            mem_addr <= grp_q | {26'h0, pidx_q, 3'h0};
            st_q     <= S_WAIT;
        end else if (st_q == S_WAIT && mem_ack) begin
            if (entry_hit) begin
                if (wway) begin
                    ubuf1[ea_q[18:12]] <= {hash_vsid(ea_q), ea_q[27:19],
                                          mem_rdata[31:12], mem_rdata[1:0]};
                    uv1_q[ea_q[18:12]] <= 1'b1;
                end else begin
                    ubuf0[ea_q[18:12]] <= {hash_vsid(ea_q), ea_q[27:19],
                                          mem_rdata[31:12], mem_rdata[1:0]};
                    uv0_q[ea_q[18:12]] <= 1'b1;
                end
                lru_q[ea_q[18:12]] <= !wway;
                st_q <= S_RETRY;
            end else if (pidx_q != `ENT_LAST) begin
                pidx_q <= pidx_q + 3'h1;
                st_q   <= S_WREQ;
            end else if (!sec_q) begin
                sec_q  <= 1'b1;
                pidx_q <= 3'h0;
                grp_q  <= grp_addr(~hash_q);
                st_q   <= S_WREQ;
            end else begin
                rsp_valid   <= 1'b1;
                rsp_paddr   <= ea_q;
                rsp_io      <= 1'b0;
                rsp_fault   <= 1'b1;
                instr_fault <= cls_q == `CL_IFETCH;
                data_fault  <= cls_q != `CL_IFETCH;
                req_ready   <= 1'b1;
                st_q        <= S_IDLE;
                if (cls_q != `CL_IFETCH) begin
                    cause_q <= 32'h0 | (32'h1 << `CS_NOTFND)
                             | ({31'h0, str_q} << `CS_STORE);
                    faddr_q <= ea_q;
                end
            end
        end
        if (reg_wr) begin
            if (reg_addr == `A_MSW)
                msw_q <= reg_wdata;
            else if (reg_addr == `A_CTRL)
                ctrl_q <= reg_wdata;
            else if (reg_addr == `A_HBASE)
                hbase_q <= reg_wdata;
            else if (reg_addr == `A_HMASK)
                hmask_q <= reg_wdata;
            else if (reg_addr[7:6] == `A_SEG_HI)
                seg_q[reg_addr[5:2]] <= reg_wdata;
            else if (reg_addr[7:5] == `A_BAT_HI && !reg_addr[2])
                bat_u[reg_addr[4:3]] <= reg_wdata;
            else if (reg_addr[7:5] == `A_BAT_HI)
                bat_l[reg_addr[4:3]] <= reg_wdata;
            // mapping changes could stale the fetch cache
            if (reg_addr[7:6] == `A_SEG_HI || reg_addr[7:5] == `A_BAT_HI)
                itv_q <= 4'h0;
        end
        // table edits are not snooped; software must invalidate
        if (inval) begin
            uv0_q[iv_idx] <= 1'b0;
            uv1_q[iv_idx] <= 1'b0;
            itv_q         <= 4'h0;
        end
        if (reg_wr && reg_addr == `A_INVAL && ctrl_q[`CTRL_BCAST]) begin
            bcast_inval <= 1'b1;
            bcast_ea    <= reg_wdata;
        end
    end
end

endmodule // address_translation_mmu

// >>> test/mmu_asserts.sv
`timescale 1ns/1ps
`include "mmu_defines.vh"

module mmu_asserts (
    // clock and reset
    input wire        mclk,
    input wire        sys_rst,
    // register port
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    // translation
    input wire        req_valid,
    input wire [1:0]  req_class,
    input wire [31:0] req_addr,
    input wire        req_ready,
    input wire        rsp_valid,
    input wire [31:0] rsp_paddr,
    input wire        rsp_io,
    input wire        rsp_fault,
    input wire        instr_fault,
    input wire        data_fault,
    // table memory and broadcast
    input wire        mem_rd,
    input wire [31:0] mem_addr,
    input wire        bcast_inval,
    input wire [31:0] bcast_ea
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    reg  [1:0]  msw_q;
    reg         bc_q;
    reg  [31:0] ea_q;
    wire        take = req_valid && req_ready;
    wire        off = req_class == `CL_IFETCH ? !msw_q[0] : !msw_q[1];
    wire        inv = reg_wr && reg_addr == `A_INVAL;
    // shadow of the enables, so checks need no peek inside
    always @(posedge mclk) begin
        if (sys_rst) begin
            msw_q <= 2'h0;
            bc_q  <= 1'b0;
            ea_q  <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == `A_MSW) msw_q <= reg_wdata[1:0];
            if (reg_wr && reg_addr == `A_CTRL) bc_q <= reg_wdata[0];
            if (take) ea_q <= req_addr;
        end
    end
    property p_off;
        take && off |=> rsp_valid && !rsp_fault && rsp_paddr == $past(req_addr);
    endproperty
    a_off: assert property (p_off) else $error("untranslated answer");
    property p_ofs;
        rsp_valid && !rsp_fault |-> rsp_paddr[11:0] == ea_q[11:0];
    endproperty
    a_ofs: assert property (p_ofs) else $error("page offset lost");
    property p_hit;
        take |=> rsp_valid || !req_ready;
    endproperty
    a_hit: assert property (p_hit) else $error("hit not at once");
    property p_walk;
        $fell(req_ready) |-> ##[0:2] mem_rd;
    endproperty
    a_walk: assert property (p_walk) else $error("no table read");
    property p_grp;
        $fell(req_ready) ##1 mem_rd |-> mem_addr[5:0] == 6'h0;
    endproperty
    a_grp: assert property (p_grp) else $error("group unaligned");
    property p_bound;
        $fell(req_ready) |-> ##[1:600] rsp_valid;
    endproperty
    a_bound: assert property (p_bound) else $error("search hangs");
    property p_bc;
        inv && bc_q |=> bcast_inval && bcast_ea == $past(reg_wdata);
    endproperty
    a_bc: assert property (p_bc) else $error("no broadcast");
    property p_nobc;
        inv && !bc_q |=> !bcast_inval;
    endproperty
    a_nobc: assert property (p_nobc) else $error("stray broadcast");
    property p_flt;
        instr_fault || data_fault |-> rsp_valid && rsp_fault
            && (instr_fault != data_fault) && rsp_paddr == ea_q;
    endproperty
    a_flt: assert property (p_flt) else $error("fault report bad");
    property p_io;
        rsp_valid && rsp_io |-> rsp_paddr == ea_q;
    endproperty
    a_io: assert property (p_io) else $error("io address changed");
endmodule // mmu_asserts

bind address_translation_mmu mmu_asserts i_chk (.*);

// >>> test/page_table_mem.sv
`timescale 1ns/1ps

module page_table_mem (
    // clock and latency
    input wire        mclk,
    input wire [1:0]  lat,
    // table port
    input wire        mem_rd,
    input wire [31:0] mem_addr,
    output reg [63:0] mem_rdata = 64'h0,
    output reg        mem_ack = 1'b0
);
    // 64k table only; base bits above 15 ignored
    reg [63:0] ent [0:8191];
    reg [12:0] idx_q;
    reg [1:0]  cnt_q;
    reg        busy_q = 1'b0;
    integer    i;
    initial begin
        for (i = 0; i < 8192; i = i + 1) ent[i] = 64'h0;
    end
    always @(posedge mclk) begin
        mem_ack <= 1'b0;
        // bus released: never hold the last value
        mem_rdata <= ~mem_rdata;
        if (mem_rd) begin
            busy_q <= 1'b1;
            cnt_q <= lat;
            idx_q <= mem_addr[15:3];
        end else if (busy_q && cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end else if (busy_q) begin
            busy_q <= 1'b0;
            mem_ack <= 1'b1;
            mem_rdata <= ent[idx_q];
        end
    end
endmodule // page_table_mem

// >>> test/tb_top.sv
`timescale 1ns/1ps
`include "mmu_defines.vh"

module tb_top;
    reg         mclk = 1'b0;
    reg         sys_rst = 1'b1;
    reg  [7:0]  reg_addr = 8'h0;
    reg  [31:0] reg_wdata = 32'h0;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg         req_valid = 1'b0;
    reg  [1:0]  req_class = 2'h0;
    reg         req_store = 1'b0;
    reg  [31:0] req_addr = 32'h0;
    reg         snoop_inval = 1'b0;
    reg  [31:0] snoop_ea = 32'h0;
    reg  [1:0]  lat = 2'h0;
    wire [31:0] reg_rdata, rsp_paddr, mem_addr, bcast_ea;
    wire [63:0] mem_rdata;
    wire        req_ready, rsp_valid, rsp_io, rsp_fault, instr_fault;
    wire        data_fault, mem_rd, mem_ack, bcast_inval;
    reg  [31:0] d, pa;
    reg         fi, fd, io;
    integer     errors = 0, check_count = 0, cyc = 0, n;
    localparam [31:0] EA_A = 32'h1234_5678, EA_B = 32'h1234_9000;
    localparam [23:0] SID = 24'h000123;

    address_translation_mmu i_dut (.*);
    page_table_mem i_mem (.*);

    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 6000) begin
            errors = errors + 1;
            stop_test;
        end
    end
    task stop_test;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task xl(input [1:0] c, input s, input [31:0] ea);
        @(posedge mclk);
        req_valid <= 1'b1;
        req_class <= c;
        req_store <= s;
        req_addr <= ea;
        @(posedge mclk);
        req_valid <= 1'b0;
        #1 n = 1;
        while (rsp_valid !== 1'b1 && n < 600) begin
            @(posedge mclk);
            #1 n = n + 1;
        end
        pa = rsp_paddr;
        fi = instr_fault;
        fd = data_fault;
        io = rsp_io;
    endtask
    // index of the primary group inside a 64k table
    function [12:0] gi(input [31:0] ea);
        gi = {(SID[9:0] ^ ea[21:12]), 3'h0};
    endfunction
    function [63:0] tbl_ent(input [31:0] ea, input [19:0] pn,
                            input [1:0] pp);
        tbl_ent = {1'b1, SID, 1'b0, ea[27:22], pn, 10'h0, pp};
    endfunction
    task blk(input [3:0] i, input [31:0] up, input [31:0] lo,
             input [31:0] ea, input [31:0] exp);
        wr(8'h80 + {i, 3'h0}, up);
        wr(8'h84 + {i, 3'h0}, lo);
        rd(8'h80 + {i, 3'h0});
        chk(d, up);
        xl(`CL_DATA, 1'b0, ea);
        chk(pa, exp);
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(`A_MSW);
        chk(d, `MSW_RST);
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20);
        chk(d, 32'h0);
        xl(`CL_DATA, 1'b0, EA_A);
        chk(pa, EA_A);
        wr(`A_MSW, 32'h2);
        xl(`CL_IFETCH, 1'b0, EA_A);
        chk(pa, EA_A);
        wr(`A_HBASE, 32'h0001_0000);
        wr(`A_HMASK, 32'h3ff);
        wr(8'h44, {8'h0, SID});
        wr(8'h48, {8'h0, SID});
        wr(8'h4c, {8'h0, SID});
        wr(8'h50, 32'h8000_0000);
        i_mem.ent[gi(EA_A) + 13'h3] = tbl_ent(EA_A, 20'habcde, `PP_RW);
        i_mem.ent[gi(EA_B) + 13'h7] = tbl_ent(EA_B, 20'h55555, `PP_RO);
        wr(`A_MSW, 32'h3);
        lat <= 2'h3;
        xl(`CL_DATA, 1'b0, EA_A);
        chk(pa, 32'habcd_e678);
        chk(n > 1, 1);
        lat <= 2'h0;
        xl(`CL_DATA, 1'b0, EA_A);
        chk(n, 1);
        xl(`CL_IFETCH, 1'b0, EA_A);
        chk(pa, 32'habcd_e678);
        i_mem.ent[gi(EA_A) + 13'h3] = tbl_ent(EA_A, 20'h11111, `PP_RW);
        xl(`CL_DATA, 1'b0, EA_A);
        chk(pa, 32'habcd_e678);
        wr(`A_CTRL, 32'h1);
        wr(`A_INVAL, EA_A);
        #1 chk(bcast_inval, 1);
        chk(bcast_ea, EA_A);
        xl(`CL_DATA, 1'b0, EA_A);
        chk(pa, 32'h1111_1678);
        xl(`CL_IFETCH, 1'b0, EA_A);
        chk(pa, 32'h1111_1678);
        i_mem.ent[gi(EA_A) + 13'h3] = tbl_ent(EA_A, 20'h22222, `PP_RW);
        @(posedge mclk);
        snoop_inval <= 1'b1;
        snoop_ea <= EA_A;
        @(posedge mclk);
        snoop_inval <= 1'b0;
        xl(`CL_DATA, 1'b0, EA_A);
        chk(pa, 32'h2222_2678);
        xl(`CL_DATA, 1'b0, 32'h1000_0000);
        chk({31'h0, fd}, 32'h1);
        chk(pa, 32'h1000_0000);
        rd(`A_CAUSE);
        chk(d & 32'h52, 32'h2);
        rd(`A_FADDR);
        chk(d, 32'h1000_0000);
        xl(`CL_DATA, 1'b1, EA_B);
        chk(fd, 1);
        rd(`A_CAUSE);
        chk(d & 32'h52, 32'h50);
        xl(`CL_DATA, 1'b0, EA_B);
        chk(pa, 32'h5555_5000);
        blk(4'h0, 32'h2000_00fd, 32'h4000_0002, 32'h2070_1234,
            32'h4070_1234);
        blk(4'h1, 32'h3000_0001, 32'h5000_0002, 32'h3001_0abc,
            32'h5001_0abc);
        xl(`CL_DATA, 1'b0, 32'h3002_0000);
        chk(fd, 1);
        xl(`CL_IOCTL, 1'b0, 32'h4000_0010);
        chk({31'h0, io}, 32'h1);
        chk(pa, 32'h4000_0010);
        xl(`CL_IFETCH, 1'b0, 32'h4000_0010);
        chk(fi, 1);
        stop_test;
    end
endmodule // tb_top
